// file: hdl/gas_sensor_i2c_command_port.sv
`timescale 1ns/10ps
`default_nettype none
module gas_sensor_i2c_command_port #(
  parameter int MS_CYCLES = sensor_cmd_pkg::CYC_PER_MS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [15:0] gas_ppm,
  input  wire logic [15:0] temp_word,
  input  wire logic [15:0] hum_word,
  output logic             dev_ready,
  output logic             cmd_busy,
  output logic             sampling_active,
  output logic             powered_down,
  output logic             result_ready
);
  localparam int MSW = sensor_cmd_pkg::MS_W;

  typedef struct packed {
    logic [MSW-1:0]            ms;
    sensor_cmd_pkg::rd_kind_type rd;
  } cmd_info_type;

  typedef struct packed {
    logic [sensor_cmd_pkg::DIV_W-1:0] div;
    logic                        ready;
    logic [MSW-1:0]              boot_ms;
    logic                        busy;
    logic [MSW-1:0]              busy_ms;
    logic [15:0]                 op;
    logic                        sampling;
    logic                        asleep;
    logic [MSW-1:0]              upd_ms;
    logic                        buf_valid;
    logic [2:0][15:0]            smp;
    logic [15:0]                 resp;
    sensor_cmd_pkg::rd_kind_type rd;
    logic [15:0]                 cmd;
    logic [1:0]                  nbytes;
    logic                        pend;
    logic [1:0]                  wsel;
    logic [1:0]                  bpos;
    logic [7:0]                  tx_byte;
  } port_type;

  target_link_if link ();

  port_type     r;
  port_type     next_r;
  logic         tick;
  logic         wr_ok;
  logic         rd_ok;
  logic         launch;
  cmd_info_type info;
  cmd_info_type done_info;

  // checksum over one data word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = sensor_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ sensor_cmd_pkg::CRC_POLY
                        : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // command code to execution time and answer kind
  function automatic cmd_info_type decode(input logic [15:0] c);
    cmd_info_type d;
    d.ms = sensor_cmd_pkg::DEFAULT_MS;
    d.rd = sensor_cmd_pkg::RD_NONE;
    unique case (c)
      sensor_cmd_pkg::CMD_BEGIN_SAMP:  d.ms = '0;
      sensor_cmd_pkg::CMD_FETCH:       d.rd = sensor_cmd_pkg::RD_SAMPLE;
      sensor_cmd_pkg::CMD_END_SAMP:    d.ms = sensor_cmd_pkg::END_MS;
      sensor_cmd_pkg::CMD_READY_QUERY: d.rd = sensor_cmd_pkg::RD_WORD;
      sensor_cmd_pkg::CMD_PRESS_COMP:  d.ms = sensor_cmd_pkg::DEFAULT_MS;
      sensor_cmd_pkg::CMD_RECAL: begin
        d.ms = sensor_cmd_pkg::RECAL_MS;
        d.rd = sensor_cmd_pkg::RD_WORD;
      end
      sensor_cmd_pkg::CMD_SAVE_NV:     d.ms = sensor_cmd_pkg::SAVE_MS;
      sensor_cmd_pkg::CMD_SELF_TEST: begin
        d.ms = sensor_cmd_pkg::TEST_MS;
        d.rd = sensor_cmd_pkg::RD_WORD;
      end
      sensor_cmd_pkg::CMD_DEFAULTS:    d.ms = sensor_cmd_pkg::DEFAULTS_MS;
      sensor_cmd_pkg::CMD_RELOAD:      d.ms = sensor_cmd_pkg::RELOAD_MS;
      sensor_cmd_pkg::CMD_ONESHOT:     d.ms = sensor_cmd_pkg::ONESHOT_MS;
      sensor_cmd_pkg::CMD_ONESHOT_RHT: d.ms = sensor_cmd_pkg::RHT_MS;
      sensor_cmd_pkg::CMD_SLEEP:       d.ms = sensor_cmd_pkg::DEFAULT_MS;
      sensor_cmd_pkg::CMD_RESUME:      d.ms = sensor_cmd_pkg::RESUME_MS;
      default:                         d.rd = sensor_cmd_pkg::RD_WORD;
    endcase
    return d;
  endfunction

  // byte of the answer at word index and byte position
  function automatic logic [7:0] answer_byte(input port_type s,
                                              input logic [1:0] w,
                                              input logic [1:0] p);
    logic [15:0] word;
    logic        have;
    word = (s.rd == sensor_cmd_pkg::RD_SAMPLE) ? s.smp[w] : s.resp;
    have = (s.rd == sensor_cmd_pkg::RD_SAMPLE) ?
           (w <= sensor_cmd_pkg::LAST_WORD) : (w == 2'h0);
    if (!have) begin
      return sensor_cmd_pkg::IDLE_BYTE;
    end
    unique case (p)
      2'h0:    return word[15:8];
      2'h1:    return word[7:0];
      default: return crc8(word);
    endcase
  endfunction

  i2c_target_engine u_engine (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .link     (link)
  );

  // handshake levels toward the bit engine
  assign tick  = r.div == MS_CYCLES[sensor_cmd_pkg::DIV_W-1:0] - 1'b1;
  assign wr_ok = r.ready & ~r.busy;
  assign rd_ok = r.ready & ~r.busy & ~r.asleep &
                 (r.rd == sensor_cmd_pkg::RD_WORD |
                  (r.rd == sensor_cmd_pkg::RD_SAMPLE & r.buf_valid));
  assign launch = r.pend & (link.ev_start | link.ev_stop) &
                  (~r.asleep | r.cmd == sensor_cmd_pkg::CMD_RESUME);
  assign info  = decode(r.cmd);
  // answer kind of the command now finishing
  assign done_info = decode(r.op);

  // command interpreter
  always_comb begin
    next_r         = r;
    next_r.div     = tick ? '0 : r.div + 1'b1;
    next_r.tx_byte = answer_byte(r, r.wsel, r.bpos);
    // power-up wait before the first command
    if (!r.ready && tick) begin
      next_r.boot_ms = r.boot_ms + 1'b1;
      if (r.boot_ms == sensor_cmd_pkg::POWERUP_MS - 1'b1) begin
        next_r.ready = 1'b1;
      end
    end
    // collect the two command bytes of a write
    if (link.ev_start) begin
      next_r.nbytes = '0;
    end
    if (link.ev_rx && r.nbytes != sensor_cmd_pkg::CMD_BYTES) begin
      next_r.nbytes = r.nbytes + 1'b1;
      if (r.nbytes == 2'h0) begin
        next_r.cmd[15:8] = link.rx_byte;
      end else begin
        next_r.cmd[7:0] = link.rx_byte;
        next_r.pend     = 1'b1;
      end
    end
    // answer pointer, moved by each byte the engine takes
    if (link.ev_addr) begin
      next_r.wsel = '0;
      next_r.bpos = '0;
    end
    if (link.ev_take) begin
      next_r.bpos = (r.bpos == sensor_cmd_pkg::CRC_POS) ? 2'h0
                                                          : r.bpos + 1'b1;
      if (r.bpos == sensor_cmd_pkg::CRC_POS) begin
        next_r.wsel = r.wsel + 1'b1;
      end
    end
    // a fetched result is consumed by its read header
    if (link.ev_addr && link.addr_rw && rd_ok &&
        r.rd == sensor_cmd_pkg::RD_SAMPLE) begin
      next_r.buf_valid = 1'b0;
    end
    // start a command once its frame closes
    if (r.pend && (link.ev_start || link.ev_stop)) begin
      next_r.pend = 1'b0;
    end
    if (launch) begin
      next_r.op      = r.cmd;
      next_r.busy    = info.ms != '0;
      next_r.busy_ms = info.ms;
      next_r.rd      = sensor_cmd_pkg::RD_NONE;
      if (r.cmd == sensor_cmd_pkg::CMD_BEGIN_SAMP) begin
        next_r.sampling = 1'b1;
        next_r.upd_ms   = '0;
      end
      if (r.cmd == sensor_cmd_pkg::CMD_END_SAMP) begin
        next_r.sampling = 1'b0;
      end
    end
    // execution countdown and completion effects
    if (r.busy && tick) begin
      next_r.busy_ms = r.busy_ms - 1'b1;
      if (r.busy_ms == sensor_cmd_pkg::DEFAULT_MS) begin
        next_r.busy = 1'b0;
        next_r.rd   = done_info.rd;
        next_r.resp = '0;
        unique case (r.op)
          sensor_cmd_pkg::CMD_READY_QUERY:
            next_r.resp = r.buf_valid ? sensor_cmd_pkg::READY_MASK : '0;
          sensor_cmd_pkg::CMD_SELF_TEST:
            next_r.resp = sensor_cmd_pkg::TEST_PASS_WORD;
          sensor_cmd_pkg::CMD_RECAL:
            next_r.resp = sensor_cmd_pkg::RECAL_WORD;
          sensor_cmd_pkg::CMD_SLEEP:
            next_r.asleep = 1'b1;
          sensor_cmd_pkg::CMD_RESUME:
            next_r.asleep = 1'b0;
          sensor_cmd_pkg::CMD_RELOAD: begin
            next_r.sampling  = 1'b0;
            next_r.buf_valid = 1'b0;
            next_r.asleep    = 1'b0;
          end
          sensor_cmd_pkg::CMD_ONESHOT: begin
            next_r.smp       = {hum_word, temp_word, gas_ppm};
            next_r.buf_valid = 1'b1;
          end
          sensor_cmd_pkg::CMD_ONESHOT_RHT: begin
            next_r.smp[1]    = temp_word;
            next_r.smp[2]    = hum_word;
            next_r.buf_valid = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    // periodic update while sampling; a new set wins over the read clear
    if (r.sampling && tick) begin
      next_r.upd_ms = r.upd_ms + 1'b1;
      if (r.upd_ms == sensor_cmd_pkg::UPDATE_MS - 1'b1) begin
        next_r.upd_ms    = '0;
        next_r.smp       = {hum_word, temp_word, gas_ppm};
        next_r.buf_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{rd: sensor_cmd_pkg::RD_NONE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // link handshake and status outputs
  assign link.wr_ok     = wr_ok;
  assign link.rd_ok     = rd_ok;
  assign link.tx_byte   = r.tx_byte;
  assign sda_out        = 1'b0;
  assign dev_ready      = r.ready;
  assign cmd_busy       = r.busy;
  assign sampling_active = r.sampling;
  assign powered_down   = r.asleep;
  assign result_ready   = r.buf_valid;
endmodule
`default_nettype wire

// file: hdl/i2c_target_engine.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_target_engine (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire logic     scl,
  input  wire logic     sda_in,
  output logic          sda_oe_n,
  target_link_if.engine link
);
  typedef struct packed {
    logic [1:0]                    scl_s;
    logic [1:0]                    sda_s;
    logic                          scl_q;
    logic                          sda_q;
    sensor_cmd_pkg::eng_state_type st;
    logic [3:0]                    bits;
    logic [7:0]                    sh;
    logic                          rw;
    logic                          macked;
    logic                          oe_n;
    logic                          ev_start;
    logic                          ev_stop;
    logic                          ev_addr;
    logic                          ev_rx;
    logic                          ev_take;
  } eng_type;

  localparam eng_type ENG_RST = '{st: sensor_cmd_pkg::E_IDLE,
    scl_s: 2'h3, sda_s: 2'h3, scl_q: 1'b1, sda_q: 1'b1, oe_n: 1'b1,
    default: '0};

  eng_type r;
  eng_type next_r;
  logic    rise;
  logic    fall;
  logic    start;
  logic    stop;

  // bus events from the second sync stage and its delayed copy
  assign rise  = r.scl_s[1] & ~r.scl_q;
  assign fall  = ~r.scl_s[1] & r.scl_q;
  assign start = r.scl_s[1] & r.scl_q & r.sda_q & ~r.sda_s[1];
  assign stop  = r.scl_s[1] & r.scl_q & ~r.sda_q & r.sda_s[1];

  // bit engine: sample on scl rise, change sda on scl fall
  always_comb begin
    next_r          = r;
    next_r.scl_s    = {r.scl_s[0], scl};
    next_r.sda_s    = {r.sda_s[0], sda_in};
    next_r.scl_q    = r.scl_s[1];
    next_r.sda_q    = r.sda_s[1];
    next_r.ev_start = 1'b0;
    next_r.ev_stop  = 1'b0;
    next_r.ev_addr  = 1'b0;
    next_r.ev_rx    = 1'b0;
    next_r.ev_take  = 1'b0;
    if (start) begin
      next_r.st       = sensor_cmd_pkg::E_ADDR;
      next_r.bits     = '0;
      next_r.oe_n     = 1'b1;
      next_r.ev_start = 1'b1;
    end else if (stop) begin
      next_r.st      = sensor_cmd_pkg::E_IDLE;
      next_r.oe_n    = 1'b1;
      next_r.ev_stop = 1'b1;
    end else if (rise) begin
      if (r.st == sensor_cmd_pkg::E_ADDR || r.st == sensor_cmd_pkg::E_RX) begin
        next_r.sh   = {r.sh[6:0], r.sda_s[1]}; // msb first
        next_r.bits = r.bits + 4'h1;
      end
      if (r.st == sensor_cmd_pkg::E_TACK) begin
        next_r.macked = ~r.sda_s[1];
      end
    end else if (fall) begin
      unique case (r.st)
        sensor_cmd_pkg::E_IDLE: begin
        end
        sensor_cmd_pkg::E_ADDR: begin
          if (r.bits == sensor_cmd_pkg::BYTE_BITS) begin
            next_r.st = sensor_cmd_pkg::E_IDLE;
            // answer only our own address
            if (r.sh[7:1] == sensor_cmd_pkg::TARGET_ADDR) begin
              next_r.rw      = r.sh[0];
              next_r.ev_addr = 1'b1;
              // read header left unacknowledged until result ready
              if (r.sh[0] ? link.rd_ok : link.wr_ok) begin
                next_r.oe_n = 1'b0;
                next_r.st   = sensor_cmd_pkg::E_AACK;
              end
            end
          end
        end
        sensor_cmd_pkg::E_AACK, sensor_cmd_pkg::E_TACK: begin
          if (r.st == sensor_cmd_pkg::E_AACK ? r.rw : r.macked) begin
            next_r.oe_n    = link.tx_byte[7];
            next_r.sh      = {link.tx_byte[6:0], 1'b0};
            next_r.bits    = 4'h1;
            next_r.ev_take = 1'b1;
            next_r.st      = sensor_cmd_pkg::E_TX;
          end else begin
            // master nack ends the read; a write header goes on to receive
            next_r.oe_n = 1'b1;
            next_r.bits = '0;
            next_r.st   = r.rw ? sensor_cmd_pkg::E_IDLE
                               : sensor_cmd_pkg::E_RX;
          end
        end
        sensor_cmd_pkg::E_RX: begin
          if (r.bits == sensor_cmd_pkg::BYTE_BITS) begin
            next_r.ev_rx = 1'b1;
            next_r.st    = sensor_cmd_pkg::E_IDLE;
            if (link.wr_ok) begin
              next_r.oe_n = 1'b0;
              next_r.st   = sensor_cmd_pkg::E_RACK;
            end
          end
        end
        sensor_cmd_pkg::E_RACK: begin
          next_r.oe_n = 1'b1;
          next_r.bits = '0;
          next_r.st   = sensor_cmd_pkg::E_RX;
        end
        sensor_cmd_pkg::E_TX: begin
          if (r.bits == sensor_cmd_pkg::BYTE_BITS) begin
            next_r.oe_n = 1'b1;
            next_r.st   = sensor_cmd_pkg::E_TACK;
          end else begin
            next_r.oe_n = r.sh[7];
            next_r.sh   = {r.sh[6:0], 1'b0};
            next_r.bits = r.bits + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= ENG_RST;
    end else begin
      r <= next_r;
    end
  end

  // event pulses and data to the interpreter
  assign sda_oe_n      = r.oe_n;
  assign link.ev_start = r.ev_start;
  assign link.ev_stop  = r.ev_stop;
  assign link.ev_addr  = r.ev_addr;
  assign link.addr_rw  = r.rw;
  assign link.ev_rx    = r.ev_rx;
  assign link.rx_byte  = r.sh;
  assign link.ev_take  = r.ev_take;
endmodule
`default_nettype wire

// file: hdl/sensor_cmd_pkg.sv
package sensor_cmd_pkg;
  // core clock and link timing
  localparam int CLK_HZ      = 125_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
  localparam int DIV_W       = 17;
  localparam int MS_W        = 14;
  localparam int SCL_MAX_KHZ = 100;

  // bus framing
  localparam logic [6:0] TARGET_ADDR = 7'h62;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [1:0] CMD_BYTES   = 2'h2;
  localparam logic [1:0] CRC_POS     = 2'h2;
  localparam logic [1:0] LAST_WORD   = 2'h2;
  localparam logic [7:0] CRC_POLY    = 8'h31;
  localparam logic [7:0] CRC_INIT    = 8'hFF;
  localparam logic [7:0] IDLE_BYTE   = 8'hFF;

  // command codes
  localparam logic [15:0] CMD_BEGIN_SAMP  = 16'h21B1;
  localparam logic [15:0] CMD_FETCH       = 16'hEC05;
  localparam logic [15:0] CMD_END_SAMP    = 16'h3F86;
  localparam logic [15:0] CMD_READY_QUERY = 16'hE4B8;
  localparam logic [15:0] CMD_PRESS_COMP  = 16'hE000;
  localparam logic [15:0] CMD_RECAL       = 16'h362F;
  localparam logic [15:0] CMD_SAVE_NV     = 16'h3615;
  localparam logic [15:0] CMD_SELF_TEST   = 16'h3639;
  localparam logic [15:0] CMD_DEFAULTS    = 16'h3632;
  localparam logic [15:0] CMD_RELOAD      = 16'h3646;
  localparam logic [15:0] CMD_ONESHOT     = 16'h219D;
  localparam logic [15:0] CMD_ONESHOT_RHT = 16'h2196;
  localparam logic [15:0] CMD_SLEEP       = 16'h36E0;
  localparam logic [15:0] CMD_RESUME      = 16'h36F6;

  // times in milliseconds
  localparam logic [MS_W-1:0] POWERUP_MS  = 14'd1000;
  localparam logic [MS_W-1:0] UPDATE_MS   = 14'd5000;
  localparam logic [MS_W-1:0] DEFAULT_MS  = 14'd1;
  localparam logic [MS_W-1:0] END_MS      = 14'd500;
  localparam logic [MS_W-1:0] RECAL_MS    = 14'd400;
  localparam logic [MS_W-1:0] SAVE_MS     = 14'd800;
  localparam logic [MS_W-1:0] TEST_MS     = 14'd10000;
  localparam logic [MS_W-1:0] DEFAULTS_MS = 14'd1200;
  localparam logic [MS_W-1:0] RELOAD_MS   = 14'd20;
  localparam logic [MS_W-1:0] ONESHOT_MS  = 14'd5000;
  localparam logic [MS_W-1:0] RHT_MS      = 14'd50;
  localparam logic [MS_W-1:0] RESUME_MS   = 14'd20;

  // fixed answer words (values arbitrary)
  localparam logic [15:0] TEST_PASS_WORD = 16'h0000;
  localparam logic [15:0] RECAL_WORD     = 16'h8000;
  localparam logic [15:0] READY_MASK     = 16'h07FF;

  typedef enum logic [1:0] {RD_NONE, RD_SAMPLE, RD_WORD} rd_kind_type;
  typedef enum logic [2:0] {
    E_IDLE, E_ADDR, E_AACK, E_RX, E_RACK, E_TX, E_TACK
  } eng_state_type;
endpackage

// file: hdl/target_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface target_link_if;
  logic       ev_start;
  logic       ev_stop;
  logic       ev_addr;
  logic       addr_rw;
  logic       ev_rx;
  logic [7:0] rx_byte;
  logic       ev_take;
  logic [7:0] tx_byte;
  logic       wr_ok;
  logic       rd_ok;
  modport engine (output ev_start, ev_stop, ev_addr, addr_rw, ev_rx,
                  rx_byte, ev_take, input tx_byte, wr_ok, rd_ok);
  modport interp (input ev_start, ev_stop, ev_addr, addr_rw, ev_rx,
                  rx_byte, ev_take, output tx_byte, wr_ok, rd_ok);
endinterface
`default_nettype wire

// file: tb/bus_controller_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_controller_model (
  input  wire logic link_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // bus idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: set data in low phase, sample mid high phase;
  // bit time is two link_clk periods, whatever the millisecond length
  task automatic bit_io(input logic b, output logic r);
    @(negedge link_clk) scl = 1'b0;
    @(posedge link_clk) sda_low = !b;
    @(negedge link_clk) scl = 1'b1;
    @(posedge link_clk) r = sda;
  endtask
  // data falls while clock is high
  task automatic start();
    @(posedge link_clk) sda_low = 1'b1;
  endtask
  // data rises while clock is high
  task automatic stop();
    @(negedge link_clk) scl = 1'b0;
    @(posedge link_clk) sda_low = 1'b1;
    @(negedge link_clk) scl = 1'b1;
    @(posedge link_clk) sda_low = 1'b0;
  endtask
  // byte out msb first, then the target acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in, then ack or a closing nack
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// file: tb/gas_sensor_i2c_command_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gas_sensor_i2c_command_port_tb;
  localparam int MS = 8;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] gas_ppm = 16'h0000;
  logic [15:0] temp_word = 16'h0000;
  logic [15:0] hum_word = 16'h0000;
  logic        scl, sda_low, sda_out, sda_oe_n, dev_ready, cmd_busy, a;
  logic        sampling_active, powered_down, result_ready;
  logic [31:0] seed = 32'h3AF4;
  logic [7:0]  q[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  wire         sda = (sda_oe_n | sda_out) & !sda_low;

  // clocks, link clock offset in phase
  always #4 core_clk = !core_clk;
  initial begin
    #3;
    forever #32 link_clk = !link_clk;
  end

  gas_sensor_i2c_command_port #(.MS_CYCLES(MS)) u_gas_sensor_i2c_command_port (
    .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .gas_ppm(gas_ppm),
    .temp_word(temp_word), .hum_word(hum_word), .dev_ready(dev_ready),
    .cmd_busy(cmd_busy), .sampling_active(sampling_active),
    .powered_down(powered_down), .result_ready(result_ready));
  bus_controller_model u_bus_controller_model (
    .link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // reference model helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = sensor_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? sensor_cmd_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic push(input logic [15:0] w);
    q.push_back(w[15:8]);
    q.push_back(w[7:0]);
    q.push_back(crc8(w));
  endtask
  // comparisons
  task automatic chk_ack(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: ack %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bus transfers
  task automatic send(input logic [7:0] adr, input logic [15:0] c,
                      output logic ack);
    logic b;
    u_bus_controller_model.start();
    u_bus_controller_model.wr(adr, ack);
    if (ack === 1'b1) begin
      u_bus_controller_model.wr(c[15:8], b);
      chk_ack(b, 1'b1);
      u_bus_controller_model.wr(c[7:0], b);
      chk_ack(b, 1'b1);
    end
    u_bus_controller_model.stop();
  endtask
  // command with one parameter word and its crc
  task automatic send_word(input logic [15:0] c, input logic [15:0] w);
    logic [39:0] p;
    logic        k;
    p = {c, w, crc8(w)};
    u_bus_controller_model.start();
    u_bus_controller_model.wr(8'hC4, k);
    chk_ack(k, 1'b1);
    for (int i = 4; i >= 0; i--) begin
      u_bus_controller_model.wr(p[i*8 +: 8], k);
      chk_ack(k, 1'b1);
    end
    u_bus_controller_model.stop();
  endtask
  task automatic fetch(input int n, output logic ack);
    logic [7:0] b;
    u_bus_controller_model.start();
    u_bus_controller_model.wr(8'hC5, ack);
    for (int i = 0; i < n && ack === 1'b1; i++) begin
      u_bus_controller_model.rd(i == n - 1, b);
      chk_byte(b, q.pop_front());
    end
    // line must stay released in the low phase after the closing nack
    fork
      u_bus_controller_model.stop();
      if (ack === 1'b1) begin
        @(negedge link_clk);
        #24;
        chk_ack(sda, 1'b1);
      end
    join
    q.delete();
  endtask
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge core_clk);
  endtask
  task automatic wait_flag(input bit pick, input int lim);
    for (int i = 0; i < lim && (pick ? result_ready : dev_ready) !== 1'b1; i++)
      @(posedge core_clk);
    if ((pick ? result_ready : dev_ready) !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_ms(2);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    chk_ack(a, 1'b0);
    wait_flag(1'b0, 1100 * MS);
    send(8'h60, sensor_cmd_pkg::CMD_FETCH, a);
    chk_ack(a, 1'b0);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    chk_ack(a, 1'b1);
    wait_ms(2);
    fetch(9, a);
    chk_ack(a, 1'b0);
    send(8'hC4, sensor_cmd_pkg::CMD_RECAL, a);
    fetch(3, a);
    chk_ack(a, 1'b0);
    wait_ms(401);
    push(sensor_cmd_pkg::RECAL_WORD);
    fetch(1, a);
    chk_ack(a, 1'b1);
    @(posedge core_clk);
    seed = xs(seed);
    gas_ppm <= seed[15:0];
    temp_word <= seed[31:16];
    seed = xs(seed);
    hum_word <= seed[15:0];
    send(8'hC4, sensor_cmd_pkg::CMD_BEGIN_SAMP, a);
    chk_ack(a, 1'b1);
    send_word(sensor_cmd_pkg::CMD_PRESS_COMP, seed[31:16]);
    wait_flag(1'b1, 5100 * MS);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    wait_ms(2);
    push(gas_ppm);
    push(temp_word);
    push(hum_word);
    fetch(9, a);
    chk_ack(a, 1'b1);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    wait_ms(2);
    fetch(9, a);
    chk_ack(a, 1'b0);
    send(8'hC4, sensor_cmd_pkg::CMD_END_SAMP, a);
    wait_ms(1);
    chk_ack(cmd_busy, 1'b1);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    chk_ack(a, 1'b0);
    chk_ack(sampling_active, 1'b0);
    wait_ms(501);
    send(8'hC4, sensor_cmd_pkg::CMD_FETCH, a);
    chk_ack(a, 1'b1);
    wait_ms(2);
    send(8'hC4, sensor_cmd_pkg::CMD_SLEEP, a);
    wait_ms(2);
    chk_ack(powered_down, 1'b1);
    send(8'hC4, sensor_cmd_pkg::CMD_RESUME, a);
    wait_ms(21);
    chk_ack(powered_down, 1'b0);
    send(8'hC4, sensor_cmd_pkg::CMD_ONESHOT_RHT, a);
    wait_ms(51);
    chk_ack(result_ready, 1'b1);
    send(8'hC4, sensor_cmd_pkg::CMD_RELOAD, a);
    wait_ms(21);
    chk_ack(result_ready, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: tb/sensor_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_port_properties #(
  parameter int MS_CYCLES = 8
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [15:0] gas_ppm,
  input wire logic [15:0] temp_word,
  input wire logic [15:0] hum_word,
  input wire logic        dev_ready,
  input wire logic        cmd_busy,
  input wire logic        sampling_active,
  input wire logic        powered_down,
  input wire logic        result_ready
);
  int boot_cnt;

  // cycles since reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) boot_cnt <= 0;
    else boot_cnt <= boot_cnt + 1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  boot_low_a: assert property (
    boot_cnt < 1000 * MS_CYCLES - 2 |-> !dev_ready)
    else $error("ready before boot wait");
  boot_high_a: assert property (
    boot_cnt > 1000 * MS_CYCLES + 4 |-> dev_ready)
    else $error("not ready after boot wait");
  ready_hold_a: assert property (dev_ready |=> dev_ready)
    else $error("ready dropped");
  quiet_boot_a: assert property (!dev_ready |-> sda_oe_n)
    else $error("data line pulled before ready");
  drive_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  busy_quiet_a: assert property (cmd_busy |-> sda_oe_n)
    else $error("acknowledge while busy");
  stop_busy_a: assert property (
    $fell(sampling_active) |-> ##[0:2] cmd_busy)
    else $error("end of sampling without busy time");
  capture_cause_a: assert property (
    $rose(result_ready) |->
      $past(sampling_active) || $past(cmd_busy) || $past(cmd_busy, 2))
    else $error("result without sampling");
  read_clear_a: assert property (
    $fell(result_ready) && sampling_active |-> ##[0:40] !sda_oe_n)
    else $error("buffer cleared without a read");
endmodule

bind gas_sensor_i2c_command_port sensor_port_properties #(
  .MS_CYCLES(MS_CYCLES)
) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .gas_ppm(gas_ppm),
  .temp_word(temp_word), .hum_word(hum_word), .dev_ready(dev_ready),
  .cmd_busy(cmd_busy), .sampling_active(sampling_active),
  .powered_down(powered_down), .result_ready(result_ready)
);
`default_nettype wire
